/* File: rtl/sto_pkg.sv */
// Purpose: Shared constants and types for the torque-off supervisor
// Assumes: 125 MHz pclk, 32-bit APB
// Notes: Register offsets are byte addresses
`default_nettype none
package sto_pkg;
   // ***********************************************
   // Clock and timing
   // ***********************************************
   localparam int CLK_MHZ = 125;
   localparam int TORQUE_OFF_US = 1000;
   localparam int TORQUE_OFF_CYC = (TORQUE_OFF_US * CLK_MHZ) - 1;
   localparam int MON_MS = 20;
   localparam int MON_CYC = (MON_MS * 1000 * CLK_MHZ) - 1;
   localparam int FAULT_FILT_US = 100;
   localparam int FAULT_FILT_CYC = FAULT_FILT_US * CLK_MHZ;
   // ***********************************************
   // Register map
   // ***********************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_EN = 8'h0C;
   localparam logic [7:0] REG_IRQ_CLR = 8'h10;
   localparam logic [7:0] REG_ID = 8'h14;
   // Arbitrary neutral identity value
   localparam logic [31:0] ID_VALUE = 32'h0000_0001;
   // ***********************************************
   // Field codes
   // ***********************************************
   localparam logic [7:0] RELAY_STO_SEL = 8'h0D;
   localparam logic [7:0] FAULT_CODE_CH = 8'h1D;
   localparam logic [1:0] SRC_TERMINAL = 2'h0;
   localparam logic [1:0] SRC_KEYPAD = 2'h1;
   localparam logic [1:0] SRC_SERIAL = 2'h2;
   // Display codes
   localparam logic [1:0] DISP_RUN = 2'h0;
   localparam logic [1:0] DISP_STOP = 2'h1;
   localparam logic [1:0] DISP_INHIBIT = 2'h2;
   localparam logic [1:0] DISP_TRIP = 2'h3;
   // Interrupt bits
   localparam int IRQ_W = 3;
   localparam int IRQ_STO_ON = 0;
   localparam int IRQ_STO_OFF = 1;
   localparam int IRQ_FAULT = 2;
   typedef enum logic [1:0] {ST_STANDBY, ST_RUN, ST_TORQUE_OFF} sto_state_t;
   // Control register fields
   typedef struct packed {
      logic [7:0] relay2_function_select;
      logic [7:0] relay1_function_select;
      logic [1:0] start_source_select;
      logic fault_reset;
   } sto_ctrl_t;
endpackage
`default_nettype wire

/* File: rtl/sto_monitor.sv */
// Purpose: Safe-torque-off supervisor with APB register access
// Assumes: Two safety channels arrive asynchronously from pins
// Notes: Torque-off path never depends on software settings
// What this block does
// - Energised input: standby, start follows source
// - De-energised input: torque off, coast stop
// - Exit needs re-energise, plus fault reset if a fault is latched
// - Restart after re-energise may be automatic
// - De-energised input shows torque-blocked message
// - Trip indication overrides torque-blocked message
// - Relay one opens when selector is 13
// - Relay two opens when selector is 13
// - Channel fault raises fault code 29
// - Monitor status changes within 20 ms
// - Fault shown, not-healthy within 20 ms
// - Torque-off can never be disabled
// - Start refused while input de-energised
// - Torque-off applies no braking
`timescale 1ns/1ns
`default_nettype none
module sto_monitor
   import sto_pkg::*;
#(
   parameter int FILT_CYC = FAULT_FILT_CYC
) (
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Safety input pins
   input wire logic sto_ch1,
   input wire logic sto_ch2,
   // Start commands per source
   input wire logic start_terminal,
   input wire logic start_keypad,
   input wire logic start_serial,
   input wire logic stop_cmd,
   // Drive trip from elsewhere
   input wire logic drive_trip,
   // Outputs to power stage and indicators
   output logic pwm_enable,
   output logic brake_enable,
   output logic sto_active,
   output logic relay1_closed,
   output logic relay2_closed,
   output logic drive_healthy,
   output logic [1:0] display_code,
   output logic [7:0] fault_code,
   output logic irq
);
   // ***********************************************
   // State
   // ***********************************************
   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
      sto_state_t st;
      sto_ctrl_t ctrl;
      logic fault;
      logic [31:0] filt;
      logic [IRQ_W-1:0] ists;
      logic [IRQ_W-1:0] ien;
      logic [31:0] rdata;
      logic run;
      logic [1:0] disp;
   } sto_state_all_t;
   sto_state_all_t q, d;
   // Synchronised channels, read only from second stage
   logic ch1, ch2, energised, mismatch, start_sel, wr, rd;
   logic [IRQ_W-1:0] ev;
   assign ch1 = q.s1[1];
   assign ch2 = q.s2[1];
   assign energised = ch1 & ch2;
   assign mismatch = ch1 ^ ch2;
   assign wr = psel & penable & pwrite;
   assign rd = psel & penable & ~pwrite;

   // Start command from selected source
   function automatic logic pick_start(input logic [1:0] src, input logic t,
                                       input logic k, input logic s);
      if (src == SRC_KEYPAD) begin
         return k;
      end else if (src == SRC_SERIAL) begin
         return s;
      end
      return t;
   endfunction
   assign start_sel = pick_start(q.ctrl.start_source_select, start_terminal,
                                 start_keypad, start_serial);

   // ***********************************************
   // Next-state logic
   // ***********************************************
   always_comb begin
      d = q;
      ev = '0;
      d.s1 = {q.s1[0], sto_ch1};
      d.s2 = {q.s2[0], sto_ch2};
      d.ctrl.fault_reset = 1'b0;
      // Channel disagreement must persist before tripping
      if (mismatch) begin
         if (q.filt < 32'(FILT_CYC)) begin
            d.filt = q.filt + 32'h0000_0001;
         end
      end else begin
         d.filt = '0;
      end
      if (mismatch && q.filt >= 32'(FILT_CYC) && !q.fault) begin
         d.fault = 1'b1;
         ev[IRQ_FAULT] = 1'b1;
      end else if (q.ctrl.fault_reset) begin
         d.fault = 1'b0;
      end
      case (q.st)
         ST_STANDBY: begin
            if (!energised) begin
               d.st = ST_TORQUE_OFF;
               ev[IRQ_STO_ON] = 1'b1;
            end else if (start_sel && !drive_trip && !q.fault) begin
               d.st = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!energised) begin
               d.st = ST_TORQUE_OFF;
               ev[IRQ_STO_ON] = 1'b1;
            end else if (stop_cmd || drive_trip || q.fault) begin
               d.st = ST_STANDBY;
            end
         end
         default: begin
            // exit needs clear fault and energised input
            // then may restart from standby at once
            if (energised && !q.fault && !q.ctrl.fault_reset) begin
               d.st = ST_STANDBY;
               ev[IRQ_STO_OFF] = 1'b1;
            end
         end
      endcase
      d.run = (d.st == ST_RUN) && energised;
      if (drive_trip || q.fault) begin
         d.disp = DISP_TRIP;
      end else if (!energised || q.st == ST_TORQUE_OFF) begin
         d.disp = DISP_INHIBIT;
      end else if (q.st == ST_RUN) begin
         d.disp = DISP_RUN;
      end else begin
         d.disp = DISP_STOP;
      end
      // Register writes; set beats clear for status
      if (wr) begin
         if (paddr == REG_CTRL) begin
            d.ctrl = pwdata[$bits(sto_ctrl_t)-1:0];
         end else if (paddr == REG_IRQ_EN) begin
            d.ien = pwdata[IRQ_W-1:0];
         end else if (paddr == REG_IRQ_CLR) begin
            d.ists = q.ists & ~pwdata[IRQ_W-1:0];
         end
      end
      d.ists = d.ists | ev;
      // Read data register
      if (rd) begin
         if (paddr == REG_CTRL) begin
            d.rdata = 32'(q.ctrl);
         end else if (paddr == REG_STAT) begin
            d.rdata = {16'h0000, fault_code, 1'b0, q.fault, q.disp,
                       sto_active, energised, ch2, ch1};
         end else if (paddr == REG_IRQ_STAT) begin
            d.rdata = 32'(q.ists);
         end else if (paddr == REG_IRQ_EN) begin
            d.rdata = 32'(q.ien);
         end else if (paddr == REG_ID) begin
            d.rdata = ID_VALUE;
         end else begin
            d.rdata = '0;
         end
      end
   end

   // ***********************************************
   // Registers
   // ***********************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.st <= ST_TORQUE_OFF;
         q.disp <= DISP_INHIBIT;
      end else if (clk_en) begin
         q <= d;
      end
   end

   // ***********************************************
   // Outputs
   // ***********************************************
   // APB: zero-wait write, one-wait read so data is registered
   logic rd_wait_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_wait_q <= 1'b0;
      end else if (clk_en) begin
         rd_wait_q <= rd & ~rd_wait_q;
      end
   end
   // Frozen cycles must not acknowledge, or a write would be lost
   assign pready = clk_en & (pwrite | rd_wait_q);
   assign pslverr = 1'b0;
   assign prdata = q.rdata;
   assign pwm_enable = q.run & energised;
   assign brake_enable = 1'b0;
   assign sto_active = (q.st == ST_TORQUE_OFF);
   assign relay1_closed = !(sto_active && q.ctrl.relay1_function_select == RELAY_STO_SEL);
   assign relay2_closed = !(sto_active && q.ctrl.relay2_function_select == RELAY_STO_SEL);
   assign drive_healthy = !q.fault && !drive_trip;
   assign fault_code = q.fault ? FAULT_CODE_CH : 8'h00;
   assign display_code = q.disp;
   assign irq = |(q.ists & q.ien);

   // ***********************************************
   // Checks
   // ***********************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Pins lost at one enabled edge: power stage cut two enabled edges on
   a_torque_off_fast: assert property (
      clk_en && !(sto_ch1 && sto_ch2) ##1 clk_en |=> !pwm_enable)
      else $error("torque not removed");
   a_status_follows: assert property (
      clk_en && !energised |=> sto_active || !clk_en) else $error("status late");
   a_no_brake: assert property (brake_enable == 1'b0) else $error("brake applied");
   a_trip_priority: assert property (
      clk_en && q.fault |=> display_code == DISP_TRIP) else $error("trip not shown");
   // Judge the exit by what the state logic saw, not what followed it
   a_exit_needs_clear: assert property (
      $fell(sto_active) |-> $past(energised) && !$past(q.fault))
      else $error("bad exit");
   a_no_start_off: assert property (
      sto_active |-> !pwm_enable) else $error("started while off");
   a_fault_unhealthy: assert property (
      q.fault |-> !drive_healthy && fault_code == FAULT_CODE_CH) else $error("fault hidden");
   a_relay1_open: assert property (
      sto_active && q.ctrl.relay1_function_select == RELAY_STO_SEL |-> !relay1_closed)
      else $error("relay1 closed");
   a_relay2_open: assert property (
      sto_active && q.ctrl.relay2_function_select == RELAY_STO_SEL |-> !relay2_closed)
      else $error("relay2 closed");
   // A disagreement that outlasts the filter latches the fault next edge
   a_fault_latch: assert property (
      clk_en && mismatch && q.filt >= 32'(FILT_CYC) && !q.ctrl.fault_reset |=> q.fault)
      else $error("fault missed");
   // ***********************************************
   // Response-time watch
   // ***********************************************
   // Cycles the input has been lost while the flag still reads clear;
   // a counter because the limit is far too long for a delay range
   logic [31:0] mon_cnt_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mon_cnt_q <= '0;
      end else if (clk_en) begin
         if (!energised && !sto_active) begin
            // Loss seen, flag not yet raised
            mon_cnt_q <= mon_cnt_q + 32'h0000_0001;
         end else begin
            mon_cnt_q <= '0;
         end
      end
   end
   a_status_timely: assert property (
      mon_cnt_q < 32'(MON_CYC)) else $error("status too slow");
   // Main scenarios: entry, run, fault, fault cleared, restart
   c_enter_off: cover property ($rose(sto_active));
   c_run: cover property ($rose(pwm_enable));
   c_fault: cover property ($rose(q.fault));
   c_fault_clear: cover property ($fell(q.fault));
   c_restart: cover property ($fell(sto_active) ##[1:8] $rose(pwm_enable));
endmodule
`default_nettype wire

/* File: dv/sto_relay_model.sv */
// Purpose: Safety relay model that feeds both safety channels
// Assumes: Bench sets the mode at pclk edges
// Notes: Mode 0 opens both, 1 closes both, 2 makes the channels disagree
`timescale 1ns/1ns
`default_nettype none
module sto_relay_model (
   // Clock and mode
   input wire logic pclk,
   input wire logic [1:0] mode,
   // Channel pins
   output logic ch1,
   output logic ch2
);
   // contacts move together
   // Disagreement only when the bench asks for it
   always_ff @(posedge pclk) begin
      ch1 <= (mode != 2'h0);
      ch2 <= (mode == 2'h1);
   end
endmodule
`default_nettype wire

/* File: dv/safe_torque_off_monitor_tb.sv */
// Purpose: Self-checking bench for the torque-off supervisor
// Assumes: Fault filter shortened to 4 cycles
// Notes: Expected values are worked out here, never read back from the design
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
   $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module safe_torque_off_monitor_tb;
   import sto_pkg::*;
   // ***************
   // Signals
   // ***************
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, ch1, ch2, st_t = 0, st_k = 0, st_s = 0, trip = 0;
   logic pwm, brake, act, rl1, rl2, healthy, irq;
   logic [1:0] disp, mode = 2'h0;
   logic [7:0] fcode;
   int err_count = 0, num_checks = 0, src;
   logic [31:0] ctl;
   // Model state: control word as written, cycles with the input lost
   logic [31:0] m_ctl = 32'h0000_0000;
   logic [1:0] m_rel;
   int m_low = 0;
   // Clock 125 MHz
   initial forever #4 pclk = ~pclk;
   sto_relay_model relay (.pclk(pclk), .mode(mode), .ch1(ch1), .ch2(ch2));
   sto_monitor #(.FILT_CYC(4)) dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .sto_ch1(ch1), .sto_ch2(ch2),
      .start_terminal(st_t), .start_keypad(st_k), .start_serial(st_s), .stop_cmd(1'b0),
      .drive_trip(trip), .pwm_enable(pwm), .brake_enable(brake), .sto_active(act),
      .relay1_closed(rl1), .relay2_closed(rl2), .drive_healthy(healthy),
      .display_code(disp), .fault_code(fcode), .irq(irq));
   // ***************
   // Tasks
   // ***************
   task automatic finish_test();
      if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // One APB transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_count++;
         finish_test();
      end
      rd = prdata;
      // Model copy of the control word, from the edge the write lands
      if (w && a == REG_CTRL) begin
         m_ctl <= d;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      cyc(2);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(rd, e)
   endtask
   // Torque-off flag, display, power stage and brake together
   task automatic outs(input logic a, input logic [1:0] dsp, input logic p);
      `CHK(act, a)
      `CHK(disp, dsp)
      `CHK(pwm, p)
      `CHK(brake, 1'b0)
   endtask
   // Rule model: once the input has been lost for three sampled edges the
   // block must be off, show inhibit or trip, and open relays set for it
   always @(posedge pclk) begin
      if (!presetn) begin
         m_low = 0;
      end else begin
         if (m_low >= 3) begin
            `CHK({act, pwm}, 2'b10)
            `CHK(disp == DISP_INHIBIT || disp == DISP_TRIP, 1'b1)
            m_rel = {m_ctl[10:3] != RELAY_STO_SEL, m_ctl[18:11] != RELAY_STO_SEL};
            `CHK({rl1, rl2}, m_rel)
         end
         m_low = (ch1 && ch2) ? 0 : m_low + 1;
      end
   end
   // Bounded run time
   initial begin
      cyc(20000);
      err_count++;
      finish_test();
   end
   // ***************
   // Main sequence
   // ***************
   initial begin
      void'($urandom(5));
      src = $urandom % 3;
      ctl = {13'h0, RELAY_STO_SEL, RELAY_STO_SEL, src[1:0], 1'b0};
      cyc(6);
      presetn <= 1'b1;
      cyc(2);
      outs(1'b1, DISP_INHIBIT, 1'b0);
      rdchk(8'h40, 32'h0000_0000);
      apb(1'b1, REG_IRQ_EN, 32'h0000_0007);
      apb(1'b1, REG_CTRL, ctl | 32'h0000_0001);
      mode <= 2'h1;
      cyc(8);
      outs(1'b0, DISP_STOP, 1'b0);
      `CHK({rl1, rl2, irq}, 3'b111)
      rdchk(REG_IRQ_STAT, 32'h0000_0002);
      apb(1'b1, REG_IRQ_CLR, 32'h0000_0007);
      `CHK(irq, 1'b0)
      {st_s, st_k, st_t} <= 3'b001 << src;
      cyc(4);
      outs(1'b0, DISP_RUN, 1'b1);
      // Masked event must not raise the line
      apb(1'b1, REG_IRQ_EN, 32'h0000_0000);
      mode <= 2'h0;
      cyc(5);
      outs(1'b1, DISP_INHIBIT, 1'b0);
      `CHK({rl1, rl2, irq}, 3'b000)
      apb(1'b1, REG_IRQ_EN, 32'h0000_0001);
      `CHK(irq, 1'b1)
      apb(1'b1, REG_IRQ_CLR, 32'h0000_0007);
      trip <= 1'b1;
      cyc(3);
      `CHK(disp, DISP_TRIP)
      trip <= 1'b0;
      {st_s, st_k, st_t} <= 3'b000;
      mode <= 2'h2;
      cyc(12);
      `CHK({fcode, healthy, disp}, {FAULT_CODE_CH, 1'b0, DISP_TRIP})
      rdchk(REG_STAT, 32'h0000_1D79);
      // Both channels back but fault still latched
      mode <= 2'h1;
      {st_s, st_k, st_t} <= 3'b001 << src;
      cyc(8);
      outs(1'b1, DISP_TRIP, 1'b0);
      apb(1'b1, REG_CTRL, ctl | 32'h0000_0001);
      cyc(8);
      outs(1'b0, DISP_RUN, 1'b1);
      `CHK({fcode, healthy}, 9'h001)
      finish_test();
   end
endmodule
`default_nettype wire
